// ### hw/sram_access_defs.vh
// Constants shared by the pipelined burst SRAM access logic.
// Assumes inclusion by bare name from design files under hw/.
`ifndef SRAM_ACCESS_DEFS_VH
`define SRAM_ACCESS_DEFS_VH

// Geometry
`define SRAM_ADDR_W 20
`define SRAM_LANES 4
`define SRAM_LANE_W 8
`define SRAM_BURST_W 2

// Burst counter values
`define BURST_FIRST 2'h0
`define BURST_STEP 2'h1

// Sleep timing, in clock cycles as printed, and in ns
`define SLEEP_ENTRY_TIME_CYC 2
`define SLEEP_RECOVERY_TIME_CYC 2
`define SLEEP_CURRENT_ENTRY_TIME_CYC 2
`define SLEEP_CURRENT_EXIT_TIME_NS 0

// Reset values of the pin synchronisers
`define OE_SYNC_RST 2'h3
`define SLEEP_SYNC_RST 2'h0

`endif

// ### hw/burst_step.v
// Two-bit burst address order: interleaved or linear.
// Assumes start and count are stable for the cycle; purely combinational.
`timescale 1ns/10ps

module burst_step (
    // Burst position
    input wire [1:0] start,
    input wire [1:0] count,
    // Order select, high for interleaved
    input wire interleave,
    // Low address bits for this beat
    output wire [1:0] low_bits
);

    wire [1:0] linear_sum;

    // Carry out of bit 1 is dropped so 11 wraps to 00
    assign linear_sum = start + count;
    assign low_bits = interleave ? (start ^ count) : linear_sum;

endmodule // burst_step

// ### hw/pipelined_burst_sram_access.v
// Bus operation logic of a pipelined burst SRAM with byte-lane writes.
// Assumes the host controller drives all synchronous inputs from CLK_SYS;
// sleep request and output drive enable arrive asynchronously.
//
// Behaviour
// - Burst order select high: low address bits step by XOR with count.
// - Burst order select low: low address bits step plus one, modulo four.
// - Selected only with all three chip enables active; else deselect.
// - Qualified load with write select high starts read at external address.
// - Read cycles with output drive enable low drive data and parity.
// - Read with output drive enable high is dummy; lines stay tristated.
// - Advance high continues burst at next address, ignoring enables.
// - Load with write select low and any byte select starts write burst.
// - Write load with no byte select is a no-operation.
// - Continue beat without byte selects advances but writes nothing.
// - Clock qualifier high: edge ignored, burst and pipeline held; synchronisers, sleep and drive enable still update.
// - Sleep request stops normal operation within two cycles.
// - Within three cycles of sleep request, lines tristated, sleep state.
// - Sleep release leaves sleep state three cycles after release.
// - Write cycles tristate every data and parity line.
// - Drive follows cycle type and output enable, masked during writes.
// - Power-up: deselected with data lines tristated.
// - Write with all byte selects high writes no bytes.
// - Each byte select gates its own data byte and parity bit.
// - Any byte select combination writes exactly the selected bytes.
// - Read data appears after the following rising edge.
// - Read or write type captured at load, kept for whole burst.
`timescale 1ns/10ps
`include "sram_access_defs.vh"

module pipelined_burst_sram_access #(
    parameter ADDR_W = `SRAM_ADDR_W,
    parameter LANES = `SRAM_LANES
) (
    // Clock and reset
    input wire CLK_SYS,
    input wire RST_N,
    // Address and burst control
    input wire [ADDR_W-1:0] ADDR,
    input wire ADVANCE_LOAD,
    input wire BURST_ORDER,
    input wire CLOCK_QUALIFIER_N,
    // Chip enables
    input wire CHIP_SELECT_ONE_N,
    input wire CHIP_SELECT_TWO,
    input wire CHIP_SELECT_THREE_N,
    // Write control
    input wire WRITE_SELECT_N,
    input wire [LANES-1:0] BYTE_WRITE_SELECTS_N,
    // Asynchronous controls
    input wire OUTPUT_DRIVE_N,
    input wire SLEEP_REQUEST,
    // Data and parity lines
    input wire [LANES*`SRAM_LANE_W-1:0] DATA_IN,
    output wire [LANES*`SRAM_LANE_W-1:0] DATA_OUT,
    output wire [LANES-1:0] PARITY_LINES_IN_UNUSED_N,
    input wire [LANES-1:0] PARITY_LINES_IN,
    output wire [LANES-1:0] PARITY_LINES_OUT,
    output wire DATA_OE,
    // Status
    output wire SLEEP_ACTIVE
);

    localparam LW = `SRAM_LANE_W;
    localparam BURST_W = `SRAM_BURST_W;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    reg [1:0] oe_sync_r;
    reg [1:0] sleep_sync_r;
    wire oe_n_s;
    wire sleep_s;

    // Output drive enable is asynchronous; a flop output costs latency
    // Limitation: drive enable reaches DATA_OE three edges late, so a
    // host must raise it that early before it drives write data itself
    always @(posedge CLK_SYS) begin
        if (!RST_N) begin
            oe_sync_r <= `OE_SYNC_RST;
            sleep_sync_r <= `SLEEP_SYNC_RST;
        end else begin
            oe_sync_r <= {oe_sync_r[0], OUTPUT_DRIVE_N};
            sleep_sync_r <= {sleep_sync_r[0], SLEEP_REQUEST};
        end
    end

    assign oe_n_s = oe_sync_r[1];
    assign sleep_s = sleep_sync_r[1];

    ////////////////////////////////////////////////////////////////////////
    // Cycle decode

    function sel_all;
        input ce1_n;
        input ce2;
        input ce3_n;
        begin
            sel_all = ~ce1_n & ce2 & ~ce3_n;
        end
    endfunction

    // Lanes to write this beat; reads and aborted beats write none
    function [LANES-1:0] lane_mask;
        input wr;
        input [LANES-1:0] sel_n;
        begin
            lane_mask = wr ? ~sel_n : {LANES{1'b0}};
        end
    endfunction

    wire en;
    wire selected;
    wire any_byte;
    wire load_rd;
    wire load_wr;

    // Qualifier high drops the edge; sleep also stops operation
    assign en = ~CLOCK_QUALIFIER_N & ~sleep_s;
    assign selected = sel_all(CHIP_SELECT_ONE_N, CHIP_SELECT_TWO,
        CHIP_SELECT_THREE_N);
    assign any_byte = ~&BYTE_WRITE_SELECTS_N;
    assign load_rd = ~ADVANCE_LOAD & selected & WRITE_SELECT_N;
    assign load_wr = ~ADVANCE_LOAD & selected & ~WRITE_SELECT_N &
        any_byte;

    ////////////////////////////////////////////////////////////////////////
    // Burst state

    reg burst_act_r;
    reg burst_wr_r;
    reg order_r;
    reg [1:0] start_r;
    reg [1:0] cnt_r;
    reg [ADDR_W-1:0] base_r;
    wire [1:0] cnt_nxt;
    wire [1:0] low_nxt;

    assign cnt_nxt = cnt_r + `BURST_STEP;

    burst_step u_step (
        .start(start_r),
        .count(cnt_nxt),
        .interleave(order_r),
        .low_bits(low_nxt)
    );

    ////////////////////////////////////////////////////////////////////////
    // Address stage, taken at the command edge

    reg a_vld_r;
    reg a_wr_r;
    reg [ADDR_W-1:0] a_addr_r;
    reg [LANES-1:0] a_be_r;

    always @(posedge CLK_SYS) begin
        if (!RST_N) begin
            burst_act_r <= 1'b0;
            burst_wr_r <= 1'b0;
            order_r <= 1'b1;
            start_r <= `BURST_FIRST;
            cnt_r <= `BURST_FIRST;
            base_r <= {ADDR_W{1'b0}};
            a_vld_r <= 1'b0;
            a_wr_r <= 1'b0;
            a_addr_r <= {ADDR_W{1'b0}};
            a_be_r <= {LANES{1'b0}};
        end else if (sleep_s) begin
            // Pending accesses are dropped at sleep entry
            burst_act_r <= 1'b0;
            a_vld_r <= 1'b0;
        end else if (en) begin
            if (!ADVANCE_LOAD) begin
                if (load_rd || load_wr) begin
                    burst_act_r <= 1'b1;
                    burst_wr_r <= load_wr;
                    order_r <= BURST_ORDER;
                    start_r <= ADDR[BURST_W-1:0];
                    cnt_r <= `BURST_FIRST;
                    base_r <= ADDR;
                    a_vld_r <= 1'b1;
                    a_wr_r <= load_wr;
                    a_addr_r <= ADDR;
                    a_be_r <= lane_mask(load_wr, BYTE_WRITE_SELECTS_N);
                end else begin
                    // Deselect or aborted write load: nothing used
                    burst_act_r <= 1'b0;
                    a_vld_r <= 1'b0;
                    a_wr_r <= 1'b0;
                    a_be_r <= {LANES{1'b0}};
                end
            end else if (burst_act_r) begin
                // Enables and write select ignored on continue beats
                cnt_r <= cnt_nxt;
                a_vld_r <= 1'b1;
                a_wr_r <= burst_wr_r;
                a_addr_r <= {base_r[ADDR_W-1:BURST_W], low_nxt};
                a_be_r <= lane_mask(burst_wr_r, BYTE_WRITE_SELECTS_N);
            end else begin
                a_vld_r <= 1'b0;
                a_wr_r <= 1'b0;
                a_be_r <= {LANES{1'b0}};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Data stage: read output or write data capture

    reg b_wr_r;
    reg [ADDR_W-1:0] b_addr_r;
    reg [LANES-1:0] b_be_r;
    reg rd_vld_r;
    reg data_oe_r;
    reg sleep_act_r;
    wire rd_vld_nxt;

    // A stall holds the whole pipeline, write completion included, so a
    // host that stalls between load and data must hold its data longer
    assign rd_vld_nxt = en ? (a_vld_r & ~a_wr_r) : rd_vld_r;

    always @(posedge CLK_SYS) begin
        if (!RST_N) begin
            b_wr_r <= 1'b0;
            b_addr_r <= {ADDR_W{1'b0}};
            b_be_r <= {LANES{1'b0}};
            rd_vld_r <= 1'b0;
            data_oe_r <= 1'b0;
            sleep_act_r <= 1'b0;
        end else begin
            // Sleep state follows the synchronised request both ways
            sleep_act_r <= sleep_s;
            if (sleep_s) begin
                b_wr_r <= 1'b0;
                rd_vld_r <= 1'b0;
            end else if (en) begin
                b_wr_r <= a_vld_r & a_wr_r;
                b_addr_r <= a_addr_r;
                b_be_r <= a_be_r;
                rd_vld_r <= a_vld_r & ~a_wr_r;
            end
            // Drive only for reads with enable low; writes mask it
            data_oe_r <= rd_vld_nxt & ~oe_n_s & ~sleep_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Byte lanes: storage, write gating, read register

    // Storage is never cleared; only the read register starts at zero.
    // Reading an address in the cycle after its write returns old data,
    // because the write lands on the same edge that the read register loads.
    wire [LANES*LW-1:0] dout_w;
    wire [LANES-1:0] pout_w;

    genvar i;
    generate
        for (i = 0; i < LANES; i = i + 1) begin : g_lane
            reg [LW:0] mem [0:(1<<ADDR_W)-1];
            reg [LW:0] q_r;

            always @(posedge CLK_SYS) begin
                // Data latched two edges after the address edge
                if (RST_N && en && b_wr_r && b_be_r[i]) begin
                    mem[b_addr_r] <= {PARITY_LINES_IN[i],
                        DATA_IN[i*LW +: LW]};
                end
            end

            always @(posedge CLK_SYS) begin
                if (!RST_N) begin
                    q_r <= {(LW+1){1'b0}};
                end else if (en && a_vld_r && !a_wr_r) begin
                    q_r <= mem[a_addr_r];
                end
            end

            assign dout_w[i*LW +: LW] = q_r[LW-1:0];
            assign pout_w[i] = q_r[LW];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign DATA_OUT = dout_w;
    assign PARITY_LINES_OUT = pout_w;
    assign PARITY_LINES_IN_UNUSED_N = {LANES{1'b1}};
    assign DATA_OE = data_oe_r;
    // Sleep status mirrors the synchronised request one edge later
    assign SLEEP_ACTIVE = sleep_act_r;

endmodule // pipelined_burst_sram_access

// ### verification/sram_chk.sv
// Port checker for the burst SRAM access block.
// Assumes a bind onto the top module; reads its ports only.
`timescale 1ns/10ps
`include "sram_access_defs.vh"
module sram_chk #(parameter ADDR_W = 20, parameter LANES = 4) (
    // Controls
    input wire CLK_SYS, RST_N, ADVANCE_LOAD, CLOCK_QUALIFIER_N,
    input wire CHIP_SELECT_ONE_N, CHIP_SELECT_TWO, CHIP_SELECT_THREE_N,
    input wire WRITE_SELECT_N, OUTPUT_DRIVE_N, SLEEP_REQUEST,
    // Results
    input wire [LANES*`SRAM_LANE_W-1:0] DATA_OUT,
    input wire DATA_OE, SLEEP_ACTIVE
);
default clocking @(posedge CLK_SYS);
endclocking
default disable iff (!RST_N);
wire go = !CLOCK_QUALIFIER_N;
// Loads near sleep are left out: sleep clears the pipeline
wire ld = go && !ADVANCE_LOAD && !SLEEP_REQUEST && !SLEEP_ACTIVE;
wire sel = !CHIP_SELECT_ONE_N && CHIP_SELECT_TWO && !CHIP_SELECT_THREE_N;
a_read_drive: assert property (
    !OUTPUT_DRIVE_N [*4] ##0 (ld && sel && WRITE_SELECT_N) ##1 go
    |=> DATA_OE) else $error("read not driven");
a_write_float: assert property (
    ld && sel && !WRITE_SELECT_N ##1 go |=> !DATA_OE)
    else $error("write beat driven");
a_desel_float: assert property (
    ld && !sel ##1 go |=> !DATA_OE) else $error("deselect driven");
a_desel_keep: assert property (
    ld && !sel ##1 (go && ADVANCE_LOAD) [*2] |=> !DATA_OE)
    else $error("continue after deselect driven");
a_oe_mask: assert property (
    OUTPUT_DRIVE_N [*4] |=> !DATA_OE) else $error("drive while disabled");
a_sleep_entry: assert property (
    SLEEP_REQUEST [*3] |=> SLEEP_ACTIVE && !DATA_OE)
    else $error("sleep not entered");
a_sleep_exit: assert property (
    !SLEEP_REQUEST [*3] |=> !SLEEP_ACTIVE) else $error("sleep not left");
a_stall_hold: assert property (
    !go |=> $stable(DATA_OUT)) else $error("data moved in stall");
a_power_up: assert property (
    disable iff (1'b0) !RST_N |=> !DATA_OE && !SLEEP_ACTIVE)
    else $error("drive out of reset");
endmodule // sram_chk

// ### verification/host_model.sv
// Host side model: presents write data two edges after the load.
// Assumes the bench flags each write beat along with its command.
`timescale 1ns/10ps
module host_model (
    // Clock and qualifier
    input wire clk,
    input wire qual_n,
    // Beat from the bench
    input wire wr,
    input wire [31:0] wd,
    // Lines toward the device
    output reg [31:0] data_o,
    output reg [3:0] par_o
);
reg s1_r = 0;
reg [31:0] d1_r = 0;
initial data_o = 0;
initial par_o = 0;
always @(posedge clk) begin
    if (!qual_n) begin
        s1_r <= wr;
        d1_r <= wd;
        // Idle lines toggle so stale data never passes as written
        data_o <= s1_r ? d1_r : ~data_o;
        par_o <= s1_r ? {d1_r[24], d1_r[16], d1_r[8], d1_r[0]} : ~par_o;
    end
end
endmodule // host_model

// ### verification/tb.sv
// Self-checking bench for the burst SRAM access block.
// Assumes the host model feeds write data; checker bound below.
`timescale 1ns/10ps
module tb;
logic CLK_SYS = 0, RST_N = 0, ADVANCE_LOAD = 0, BURST_ORDER = 0, wr = 0;
logic CLOCK_QUALIFIER_N = 0, CHIP_SELECT_ONE_N = 0, CHIP_SELECT_TWO = 0;
logic CHIP_SELECT_THREE_N = 0, WRITE_SELECT_N = 1, OUTPUT_DRIVE_N = 0;
logic SLEEP_REQUEST = 0, DATA_OE, SLEEP_ACTIVE;
logic [5:0] ADDR = 0;
logic [3:0] BYTE_WRITE_SELECTS_N = 4'hF, PARITY_LINES_IN, PARITY_LINES_OUT;
logic [31:0] DATA_IN, DATA_OUT, wd = 0;
logic [35:0] mem [64], pend, s1;
logic pend_rd = 0, s1_rd = 0, q_drv = 0, b_rd = 0, b_ok = 0;
logic ord = 0, desel = 0, oe_n = 0, nap = 0;
int bad_count = 0, checks = 0;
pipelined_burst_sram_access #(.ADDR_W(6)) DUT (.*,
    .PARITY_LINES_IN_UNUSED_N());
host_model HOST (.clk(CLK_SYS), .qual_n(CLOCK_QUALIFIER_N), .wr(wr),
    .wd(wd), .data_o(DATA_IN), .par_o(PARITY_LINES_IN));
initial begin
    forever #2 CLK_SYS = ~CLK_SYS;
end
////////////////////////////////
task cmp(input logic [35:0] g, x);
    checks++;
    if (g !== x) begin
        bad_count++;
        $display("mismatch t=%0t got=%h exp=%h", $time, g, x);
    end
endtask
// One bus cycle; read results are judged two qualified edges later
task cmd(input logic adv, wen, input logic [3:0] bw,
    input logic [5:0] a, input logic [31:0] d, input logic q);
    logic c;
    logic [35:0] e;
    @(posedge CLK_SYS);
    c = !q_drv && s1_rd;
    e = s1;
    if (!q_drv) begin
        s1_rd = pend_rd;
        s1 = pend;
    end
    ADVANCE_LOAD <= adv;
    WRITE_SELECT_N <= wen;
    BYTE_WRITE_SELECTS_N <= bw;
    ADDR <= a;
    wd <= d;
    CLOCK_QUALIFIER_N <= q;
    CHIP_SELECT_TWO <= !desel;
    BURST_ORDER <= ord;
    OUTPUT_DRIVE_N <= oe_n;
    SLEEP_REQUEST <= nap;
    if (!q && !adv) begin
        b_rd = wen;
        b_ok = !desel && (wen || bw != 4'hF);
    end
    wr <= !q && b_ok && !b_rd;
    pend_rd = !q && b_ok && b_rd && !oe_n;
    pend = mem[a];
    for (int i = 0; i < 4; i++)
        if (!q && b_ok && !b_rd && !bw[i])
            {mem[a][32+i], mem[a][8*i+:8]} = {d[8*i], d[8*i+:8]};
    q_drv = q;
    #1;
    if (c) begin
        cmp(DATA_OE, 1);
        cmp({PARITY_LINES_OUT, DATA_OUT}, e);
    end
endtask
task idle(input int n);
    desel = 1;
    repeat (n) cmd(0, 1, 4'hF, 0, 0, 0);
    desel = 0;
endtask
task burst(input logic o, wen, input logic [5:0] a0, input logic [3:0] m);
    ord = o;
    for (int k = 0; k < 4; k++)
        cmd(k != 0, wen, k == 1 ? m : 4'h0, {a0[5:2], o ? a0[1:0] ^ 2'(k)
            : a0[1:0] + 2'(k)}, {4{2'(k), a0}}, 0);
endtask
task t_orders;
    burst(0, 0, 6'h11, 4'h0);
    burst(1, 0, 6'h22, 4'h0);
    idle(2);
    burst(1, 1, 6'h11, 4'h0);
    burst(0, 1, 6'h20, 4'h0);
endtask
task t_bytes;
    cmd(0, 0, 4'hA, 6'h11, 32'h76543210, 0);
    cmd(0, 0, 4'hF, 6'h12, 32'h0, 0);
    burst(0, 0, 6'h20, 4'hF);
    idle(2);
    cmd(0, 1, 4'hF, 6'h11, 0, 0);
    cmd(0, 1, 4'hF, 6'h12, 0, 0);
    burst(0, 1, 6'h20, 4'h0);
    idle(2);
endtask
task t_dummy;
    oe_n = 1;
    idle(4);
    cmd(0, 1, 4'hF, 6'h13, 0, 0);
    idle(2);
    cmp(DATA_OE, 0);
    oe_n = 0;
    idle(4);
endtask
task t_desel;
    cmd(1, 1, 4'hF, 6'h11, 0, 0);
    cmd(1, 1, 4'hF, 6'h12, 0, 0);
    cmp(DATA_OE, 0);
endtask
// Stalled write load must leave its target untouched
task t_stall;
    cmd(0, 1, 4'hF, 6'h13, 0, 0);
    repeat (2) cmd(0, 0, 4'h0, 6'h10, 32'hFFFFFFFF, 1);
    idle(2);
    cmd(0, 1, 4'hF, 6'h10, 0, 0);
    idle(2);
endtask
task t_sleep;
    nap = 1;
    idle(5);
    cmp(SLEEP_ACTIVE, 1);
    cmp(DATA_OE, 0);
    nap = 0;
    idle(4);
    cmp(SLEEP_ACTIVE, 0);
    cmd(0, 1, 4'hF, 6'h12, 0, 0);
    idle(2);
endtask
task complete_run;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
        $display("RESULT: PASS");
    else
        $display("RESULT: FAIL");
    $finish;
endtask
initial begin
    repeat (2) @(posedge CLK_SYS);
    RST_N <= 1;
    #1;
    cmp(DATA_OE, 0);
    cmp(SLEEP_ACTIVE, 0);
    t_orders;
    t_bytes;
    t_dummy;
    t_desel;
    t_stall;
    t_sleep;
    complete_run;
end
// Whole run needs well under a thousand cycles
initial begin
    #20000;
    bad_count++;
    complete_run;
end
endmodule // tb
bind pipelined_burst_sram_access sram_chk
    #(.ADDR_W(ADDR_W), .LANES(LANES)) chk (.*);
